/* verilog/iabx_pkg.sv */
// constants and types shared by the integer/branch decode-execute block
package iabx_pkg;
  localparam int XLEN = 64;
  localparam int WLEN = 32;
  localparam int IMMW = 16;
  localparam int RIDXW = 5;
  localparam int SRCOND_BIT = 18;
  localparam int OVF_CARRY_LO = 30;
  localparam int OVF_CARRY_HI = 31;
  localparam int BR_SHIFT = 2;
  localparam int INSTR_BYTES = 4;
  localparam int NUM_GPR = 32;
  // instruction fields
  localparam int OP_HI = 31;
  localparam int OP_LO = 26;
  localparam int RA_HI = 25;
  localparam int RA_LO = 21;
  localparam int RB_HI = 20;
  localparam int RB_LO = 16;
  localparam int RD_HI = 15;
  localparam int RD_LO = 11;
  localparam int SH_HI = 10;
  localparam int SH_LO = 6;
  localparam int FN_HI = 5;
  localparam int FN_LO = 0;
  // major opcodes
  localparam logic [5:0] OP_REGFMT = 6'h00;
  localparam logic [5:0] OP_SUM_TRAP_IMM = 6'h08;
  localparam logic [5:0] OP_SUM_NOTRAP_IMM = 6'h09;
  localparam logic [5:0] OP_CONJ_IMM = 6'h0c;
  localparam logic [5:0] OP_BR_EQ = 6'h04;
  localparam logic [5:0] OP_BR_EQ_LIKELY = 6'h14;
  localparam logic [5:0] OP_SYSCTL = 6'h10;
  // system-control sub-opcodes
  localparam logic [4:0] SUB_BRANCH = 5'h08;
  localparam logic [4:0] SUB_MOVE_FROM = 5'h00;
  localparam logic [4:0] SUB_MOVE_TO = 5'h04;
  localparam logic [4:0] SEL_FALSE = 5'h00;
  localparam logic [4:0] SEL_TRUE = 5'h01;
  localparam logic [4:0] SEL_FALSE_LIKELY = 5'h02;
  localparam logic [4:0] SEL_TRUE_LIKELY = 5'h03;
  // function field
  localparam logic [5:0] FN_SUM_TRAP = 6'h20;
  localparam logic [5:0] FN_SUM_NOTRAP = 6'h21;
  localparam logic [5:0] FN_CONJ = 6'h24;
  localparam logic [4:0] SHAMT_ZERO = 5'h00;
  localparam logic [4:0] REG_ZERO = 5'h00;

  typedef enum logic [2:0] {
    OPK_NONE, OPK_SUM, OPK_CONJ, OPK_BR_EQ, OPK_BR_COND, OPK_SC_MOVE
  } iabx_opk_e;

  typedef enum logic [1:0] {
    IDLE, SLOT_PENDING
  } iabx_state_e;
endpackage

/* verilog/iabx_dec_if.sv */
// decoded instruction bundle between decoder and top
`timescale 1ns/100ps
`default_nettype none
interface iabx_dec_if;
  import iabx_pkg::*;
  iabx_opk_e kind;
  logic trap;
  logic useImm;
  logic immZeroExt;
  logic likely;
  logic wantTrue;
  logic writeToB;
  logic scMoveTo;
  modport dec (output kind, trap, useImm, immZeroExt, likely, wantTrue, writeToB, scMoveTo);
  modport exe (input kind, trap, useImm, immZeroExt, likely, wantTrue, writeToB, scMoveTo);
endinterface
`default_nettype wire

/* verilog/iabx_decoder.sv */
// instruction decoder for sums, conjunctions and the branches of this group
`timescale 1ns/100ps
`default_nettype none
module iabx_decoder (
  // instruction word
  input wire logic [31:0] instr,
  // decoded result
  iabx_dec_if.dec dec
);
  import iabx_pkg::*;
  logic [5:0] op;
  logic [4:0] sub;
  logic [4:0] sel;
  logic [4:0] sh;
  logic [5:0] fn;
  assign op = instr[OP_HI:OP_LO];
  assign sub = instr[RA_HI:RA_LO];
  assign sel = instr[RB_HI:RB_LO];
  assign sh = instr[SH_HI:SH_LO];
  assign fn = instr[FN_HI:FN_LO];

  always_comb begin
    dec.kind = OPK_NONE;
    dec.trap = 1'b0;
    dec.useImm = 1'b0;
    dec.immZeroExt = 1'b0;
    dec.likely = 1'b0;
    dec.wantTrue = 1'b0;
    dec.writeToB = 1'b0;
    dec.scMoveTo = 1'b0;
    if (op == OP_REGFMT && sh == SHAMT_ZERO) begin
      if (fn == FN_SUM_TRAP) begin
        dec.kind = OPK_SUM;
        dec.trap = 1'b1;
      end else if (fn == FN_SUM_NOTRAP) begin
        dec.kind = OPK_SUM;
      end else if (fn == FN_CONJ) begin
        dec.kind = OPK_CONJ;
      end
    end else if (op == OP_SUM_TRAP_IMM) begin
      dec.kind = OPK_SUM;
      dec.trap = 1'b1;
      dec.useImm = 1'b1;
      dec.writeToB = 1'b1;
    end else if (op == OP_SUM_NOTRAP_IMM) begin
      dec.kind = OPK_SUM;
      dec.useImm = 1'b1;
      dec.writeToB = 1'b1;
    end else if (op == OP_CONJ_IMM) begin
      dec.kind = OPK_CONJ;
      dec.useImm = 1'b1;
      dec.immZeroExt = 1'b1;
      dec.writeToB = 1'b1;
    end else if (op == OP_BR_EQ) begin
      dec.kind = OPK_BR_EQ;
    end else if (op == OP_BR_EQ_LIKELY) begin
      dec.kind = OPK_BR_EQ;
      dec.likely = 1'b1;
    end else if (op == OP_SYSCTL) begin
      if (sub == SUB_BRANCH) begin
        if (sel == SEL_FALSE) begin
          dec.kind = OPK_BR_COND;
        end else if (sel == SEL_TRUE) begin
          dec.kind = OPK_BR_COND;
          dec.wantTrue = 1'b1;
        end else if (sel == SEL_FALSE_LIKELY) begin
          dec.kind = OPK_BR_COND;
          dec.likely = 1'b1;
        end else if (sel == SEL_TRUE_LIKELY) begin
          dec.kind = OPK_BR_COND;
          dec.wantTrue = 1'b1;
          dec.likely = 1'b1;
        end
      end else if (sub == SUB_MOVE_FROM) begin
        dec.kind = OPK_SC_MOVE;
      end else if (sub == SUB_MOVE_TO) begin
        dec.kind = OPK_SC_MOVE;
        dec.scMoveTo = 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

/* verilog/iabx_gpr_file.sv */
// general register file with register zero hardwired
`timescale 1ns/100ps
`default_nettype none
module iabx_gpr_file #(
  parameter int WIDTH = 64,
  parameter int NREG = 32
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // read ports
  input wire logic [4:0] rdAddrA,
  input wire logic [4:0] rdAddrB,
  output logic [WIDTH-1:0] rdDataA,
  output logic [WIDTH-1:0] rdDataB,
  // write port
  input wire logic wrEn,
  input wire logic [4:0] wrAddr,
  input wire logic [WIDTH-1:0] wrData
);
  import iabx_pkg::*;
  logic [WIDTH-1:0] mem [NREG];
  // index zero is never stored, so it always reads zero
  assign rdDataA = (rdAddrA == REG_ZERO) ? '0 : mem[rdAddrA];
  assign rdDataB = (rdAddrB == REG_ZERO) ? '0 : mem[rdAddrB];

  for (genvar i = 0; i < NREG; i++) begin : g_reg
    always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
        mem[i] <= '0;
      end else if (wrEn && wrAddr == 5'(i) && i != 0) begin
        mem[i] <= wrData;
      end
    end
  end
endmodule
`default_nettype wire

/* verilog/iabx_exec.sv */
// decode-execute stage for sums, conjunctions, sysctl-condition branches and equal branches
`timescale 1ns/100ps
`default_nettype none
module iabx_exec #(
  parameter int XW = 64
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // instruction issue, one instruction per asserted cycle
  input wire logic instrValid,
  input wire logic [31:0] instrWord,
  input wire logic [XW-1:0] instrPc,
  // status word bit from the system-control unit
  input wire logic statusCond,
  // redirect to fetch
  output logic redirectValid,
  output logic [XW-1:0] redirectPc,
  // delay-slot nullification
  output logic slotNullified,
  // exceptions
  output logic ovfException,
  output logic [XW-1:0] exceptionReturnPc,
  // system-control move request
  output logic scMoveValid,
  output logic scMoveTo,
  output logic [4:0] scRegIdx,
  output logic [4:0] scGprIdx,
  // debug read port of the general registers
  input wire logic [4:0] dbgRegIdx,
  output logic [XW-1:0] dbgRegData,
  // retirement
  output logic retireValid
);
  import iabx_pkg::*;

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    iabx_state_e state;
    logic [XW-1:0] branchTarget;
    logic branchTaken;
    logic branchLikely;
    logic [XW-1:0] branchPc;
    logic condSampled;
    logic redirectValid;
    logic [XW-1:0] redirectPc;
    logic slotNullified;
    logic ovfException;
    logic [XW-1:0] exceptionReturnPc;
    logic scMoveValid;
    logic scMoveTo;
    logic [4:0] scRegIdx;
    logic [4:0] scGprIdx;
    logic [XW-1:0] dbgRegData;
    logic retireValid;
  } iabx_state_s;

  iabx_state_s st_reg;
  iabx_state_s st_next;

  // ----------------------------------------
  // decode and operands
  // ----------------------------------------
  iabx_dec_if decBus ();

  iabx_decoder u_dec (
    .instr(instrWord),
    .dec(decBus.dec)
  );

  logic [4:0] idxA;
  logic [4:0] idxB;
  logic [4:0] idxD;
  logic [XW-1:0] opA;
  logic [XW-1:0] opB;
  logic [XW-1:0] dbgData;
  logic gprWe;
  logic [4:0] gprWa;
  logic [XW-1:0] gprWd;
  logic statusSync1;
  logic statusSync2;

  assign idxA = instrWord[RA_HI:RA_LO];
  assign idxB = instrWord[RB_HI:RB_LO];
  assign idxD = instrWord[RD_HI:RD_LO];

  iabx_gpr_file #(
    .WIDTH(XW),
    .NREG(NUM_GPR)
  ) u_gpr (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .rdAddrA(idxA),
    .rdAddrB(instrValid ? idxB : dbgRegIdx),
    .rdDataA(opA),
    .rdDataB(opB),
    .wrEn(gprWe),
    .wrAddr(gprWa),
    .wrData(gprWd)
  );
  assign dbgData = opB;

  // status bit comes from another unit's timing; keep it two flops deep
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      statusSync1 <= 1'b0;
      statusSync2 <= 1'b0;
    end else begin
      statusSync1 <= statusCond;
      statusSync2 <= statusSync1;
    end
  end

  // ----------------------------------------
  // arithmetic
  // ----------------------------------------
  logic [IMMW-1:0] imm;
  logic [XW-1:0] immSext;
  logic [XW-1:0] immZext;
  logic [XW-1:0] addend;
  logic [WLEN-1:0] opALow;
  logic [WLEN-1:0] addendLow;
  logic [WLEN:0] sum33;
  logic [WLEN-1:0] sumLow;
  logic carry30;
  logic carry31;
  logic overflow;
  logic [XW-1:0] sumResult;
  logic [XW-1:0] conjResult;
  logic [XW-1:0] brOffset;
  logic condMet;
  logic isBranch;

  assign imm = instrWord[IMMW-1:0];
  assign immSext = {{(XW-IMMW){imm[IMMW-1]}}, imm};
  assign immZext = {{(XW-IMMW){1'b0}}, imm};
  assign addend = decBus.useImm ? immSext : opB;
  // only the low word takes part; the upper halves are sign copies by contract
  assign opALow = opA[WLEN-1:0];
  assign addendLow = addend[WLEN-1:0];
  assign sum33 = {1'b0, opALow} + {1'b0, addendLow};
  assign sumLow = sum33[WLEN-1:0];
  // carry out of bit 30 is the carry into bit 31
  assign carry30 = opA[OVF_CARRY_HI] ^ addend[OVF_CARRY_HI] ^ sumLow[OVF_CARRY_HI];
  assign carry31 = sum33[WLEN];
  assign overflow = decBus.trap && (carry30 != carry31);
  assign sumResult = {{(XW-WLEN){sumLow[WLEN-1]}}, sumLow};
  assign conjResult = opA & (decBus.immZeroExt ? immZext : opB);
  // delay-slot address is the branch address plus one word
  assign brOffset = {{(XW-IMMW-BR_SHIFT){imm[IMMW-1]}}, imm, {BR_SHIFT{1'b0}}};
  assign isBranch = decBus.kind == OPK_BR_EQ || decBus.kind == OPK_BR_COND;
  always_comb begin
    condMet = 1'b0;
    case (decBus.kind)
      OPK_BR_EQ: begin
        condMet = (opA == opB);
      end
      OPK_BR_COND: begin
        // flag value as it stood at the preceding instruction
        condMet = decBus.wantTrue ? st_reg.condSampled : !st_reg.condSampled;
      end
      default: begin
        condMet = 1'b0;
      end
    endcase
  end

  // ----------------------------------------
  // result selection
  // ----------------------------------------
  logic writesResult;
  logic [XW-1:0] resultData;
  logic [4:0] resultIdx;
  logic isSlot;
  logic slotKilled;
  logic [XW-1:0] slotPc;
  logic [XW-1:0] targetNext;

  // branches and moves never write a general register from here
  always_comb begin
    writesResult = 1'b0;
    resultData = sumResult;
    case (decBus.kind)
      OPK_SUM: begin
        writesResult = 1'b1;
        resultData = sumResult;
      end
      OPK_CONJ: begin
        writesResult = 1'b1;
        resultData = conjResult;
      end
      default: begin
        writesResult = 1'b0;
        resultData = sumResult;
      end
    endcase
  end
  // immediate forms name their destination in the second source field
  assign resultIdx = decBus.writeToB ? idxB : idxD;
  // a likely branch that falls through discards its slot
  assign isSlot = st_reg.state == SLOT_PENDING;
  assign slotKilled = isSlot && st_reg.branchLikely && !st_reg.branchTaken;
  assign slotPc = instrPc + XW'(INSTR_BYTES);
  assign targetNext = slotPc + brOffset;

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    st_next = st_reg;
    st_next.redirectValid = 1'b0;
    st_next.slotNullified = 1'b0;
    st_next.ovfException = 1'b0;
    st_next.scMoveValid = 1'b0;
    st_next.retireValid = 1'b0;
    st_next.dbgRegData = instrValid ? st_reg.dbgRegData : dbgData;
    gprWe = 1'b0;
    gprWa = resultIdx;
    gprWd = resultData;
    if (instrValid) begin
      st_next.condSampled = statusSync2;
      case (st_reg.state)
        SLOT_PENDING: begin
          st_next.state = IDLE;
          if (slotKilled) begin
            st_next.slotNullified = 1'b1;
          end else begin
            if (overflow) begin
              st_next.ovfException = 1'b1;
              st_next.exceptionReturnPc = st_reg.branchPc;
            end else begin
              gprWe = writesResult;
              st_next.retireValid = 1'b1;
            end
            st_next.scMoveValid = decBus.kind == OPK_SC_MOVE;
          end
          if (st_reg.branchTaken) begin
            st_next.redirectValid = 1'b1;
            st_next.redirectPc = st_reg.branchTarget;
          end
        end
        IDLE: begin
          if (overflow) begin
            st_next.ovfException = 1'b1;
            st_next.exceptionReturnPc = instrPc;
          end else begin
            gprWe = writesResult;
            st_next.retireValid = 1'b1;
          end
          st_next.scMoveValid = decBus.kind == OPK_SC_MOVE;
          if (isBranch) begin
            st_next.state = SLOT_PENDING;
            st_next.branchTaken = condMet;
            st_next.branchLikely = decBus.likely;
            st_next.branchPc = instrPc;
            st_next.branchTarget = targetNext;
          end
        end
        // unused encodings fall back to plain issue on the next instruction
        default: begin
          st_next.state = IDLE;
        end
      endcase
      // only the move instructions reach system-control registers
      st_next.scMoveTo = decBus.scMoveTo;
      st_next.scRegIdx = idxD;
      st_next.scGprIdx = idxB;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign redirectValid = st_reg.redirectValid;
  assign redirectPc = st_reg.redirectPc;
  assign slotNullified = st_reg.slotNullified;
  assign ovfException = st_reg.ovfException;
  assign exceptionReturnPc = st_reg.exceptionReturnPc;
  assign scMoveValid = st_reg.scMoveValid;
  assign scMoveTo = st_reg.scMoveTo;
  assign scRegIdx = st_reg.scRegIdx;
  assign scGprIdx = st_reg.scGprIdx;
  assign dbgRegData = st_reg.dbgRegData;
  assign retireValid = st_reg.retireValid;
endmodule
`default_nettype wire

/* testbench/iabx_assertions.sv */
// concurrent checks on the ports of the integer/branch decode-execute stage
`timescale 1ns/100ps
`default_nettype none
module iabx_assertions #(
  parameter int XW = 64
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // issue
  input wire logic instrValid,
  input wire logic [31:0] instrWord,
  input wire logic [XW-1:0] instrPc,
  // answers
  input wire logic redirectValid,
  input wire logic [XW-1:0] redirectPc,
  input wire logic slotNullified,
  input wire logic ovfException,
  input wire logic scMoveValid,
  input wire logic scMoveTo,
  input wire logic [4:0] scRegIdx,
  input wire logic [4:0] scGprIdx,
  input wire logic retireValid
);
  import iabx_pkg::*;
  // word of the last issued instruction, so the slot's answer can see its branch
  logic [31:0] lastWord_reg;
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      lastWord_reg <= '0;
    end else if (instrValid) begin
      lastWord_reg <= instrWord;
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  // ----------------------------------------
  // properties
  // ----------------------------------------
  a_ovf_trap_only: assert property (ovfException |-> $past(instrValid) &&
    ($past(instrWord[31:26]) == OP_SUM_TRAP_IMM || $past(instrWord[5:0]) == FN_SUM_TRAP)) else $error("bad ovf");
  a_ovf_no_retire: assert property (ovfException |-> !retireValid) else $error("ovf retired");
  a_notrap_never: assert property (instrValid && instrWord[31:26] == OP_SUM_NOTRAP_IMM
    |=> !ovfException) else $error("nontrapping sum trapped");
  a_move_only_sysctl: assert property (scMoveValid |-> $past(instrWord[31:26]) == OP_SYSCTL)
    else $error("move from other op");
  a_move_fields: assert property (instrValid && instrWord[31:21] == {OP_SYSCTL, SUB_MOVE_TO} |=>
    slotNullified || (scMoveValid && scMoveTo && scRegIdx == $past(instrWord[15:11]))) else $error("move");
  a_branch_target: assert property (redirectValid |-> redirectPc == $past(instrPc) +
    {{(XW-18){$past(lastWord_reg[15])}}, $past(lastWord_reg[15:0]), 2'b00}) else $error("bad target");
  a_nullify_excl: assert property (slotNullified |-> !retireValid && !redirectValid)
    else $error("nullified slot retired");
  a_redirect_once: assert property ($rose(redirectValid) |=> !redirectValid) else $error("long redirect");
  c_redirect: cover property (redirectValid);
  c_nullify: cover property (slotNullified);
  c_ovf: cover property (ovfException);
  c_move: cover property (scMoveValid && !scMoveTo);
endmodule
bind iabx_exec iabx_assertions #(.XW(XW)) u_chk (.clk_sys(clk_sys), .rstn(rstn), .instrValid(instrValid),
  .instrWord(instrWord), .instrPc(instrPc), .redirectValid(redirectValid), .redirectPc(redirectPc),
  .slotNullified(slotNullified), .ovfException(ovfException), .scMoveValid(scMoveValid),
  .scMoveTo(scMoveTo), .scRegIdx(scRegIdx), .scGprIdx(scGprIdx), .retireValid(retireValid));
`default_nettype wire

/* testbench/int_arith_logic_branch_exec_bench.sv */
// self-checking bench for the integer/branch decode-execute stage
`timescale 1ns/100ps
`default_nettype none
module int_arith_logic_branch_exec_bench;
  import iabx_pkg::*;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic instrValid = 1'b0;
  logic [31:0] instrWord = '0;
  logic [63:0] instrPc = '0;
  logic statusCond = 1'b0;
  logic [4:0] dbgRegIdx = '0;
  logic redirectValid, slotNullified, ovfException, scMoveValid, scMoveTo, retireValid;
  logic [63:0] redirectPc, exceptionReturnPc, dbgRegData;
  logic [4:0] scRegIdx, scGprIdx;
  logic [63:0] pc = 64'h1000;
  int nErrors = 0;
  int numChecks = 0;
  iabx_exec #(.XW(64)) i_dut (.clk_sys(clk_sys), .rstn(rstn), .instrValid(instrValid),
    .instrWord(instrWord), .instrPc(instrPc), .statusCond(statusCond), .redirectValid(redirectValid),
    .redirectPc(redirectPc), .slotNullified(slotNullified), .ovfException(ovfException),
    .exceptionReturnPc(exceptionReturnPc), .scMoveValid(scMoveValid), .scMoveTo(scMoveTo),
    .scRegIdx(scRegIdx), .scGprIdx(scGprIdx), .dbgRegIdx(dbgRegIdx), .dbgRegData(dbgRegData),
    .retireValid(retireValid));
  initial begin
    forever #50 clk_sys = ~clk_sys;
  end
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic chk(input string nm, input logic [63:0] got, input logic [63:0] exp);
    numChecks++;
    if (got !== exp) begin
      nErrors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask
  function automatic logic [31:0] iw(logic [5:0] op, logic [4:0] a, logic [4:0] b, logic [15:0] im);
    return {op, a, b, im};
  endfunction
  function automatic logic [31:0] rw(logic [4:0] a, logic [4:0] b, logic [4:0] d, logic [4:0] sh, logic [5:0] fn);
    return {OP_REGFMT, a, b, d, sh, fn};
  endfunction
  task automatic ex(input logic [31:0] w);
    @(posedge clk_sys);
    instrValid <= 1'b1;
    instrWord <= w;
    instrPc <= pc;
    pc = pc + 64'h4;
  endtask
  task automatic fin();
    @(posedge clk_sys);
    instrValid <= 1'b0;
    #1;
  endtask
  // one instruction alone, with a gap after it so dependent operands are settled
  task automatic op1(input logic [31:0] w, input logic ovf);
    ex(w);
    fin();
    chk("ovf", ovfException, ovf);
    chk("retire", retireValid, !ovf);
    chk("scmove", scMoveValid, 1'b0);
  endtask
  task automatic rd(input logic [4:0] r, input logic [63:0] exp);
    @(posedge clk_sys);
    dbgRegIdx <= r;
    @(posedge clk_sys);
    #1;
    chk("gpr", dbgRegData, exp);
  endtask
  task automatic br(input logic [31:0] b, input logic [31:0] s, input logic tk, input logic lk);
    logic [63:0] bp;
    bp = pc;
    ex(b);
    ex(s);
    #1;
    chk("early redirect", redirectValid, 1'b0);
    fin();
    chk("redirect", redirectValid, tk);
    if (tk) chk("target", redirectPc, bp + 64'h4 + {{46{b[15]}}, b[15:0], 2'b00});
    chk("nullify", slotNullified, lk && !tk);
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_sum();
    op1(iw(OP_SUM_NOTRAP_IMM, 5'd0, 5'd1, 16'hffff), 1'b0);
    rd(5'd1, '1);
    op1(iw(OP_SUM_NOTRAP_IMM, 5'd0, 5'd3, 16'h8000), 1'b0);
    for (int k = 0; k < 16; k++) op1(rw(5'd3, 5'd3, 5'd3, 5'd0, FN_SUM_NOTRAP), 1'b0);
    rd(5'd3, 64'hffffffff80000000);
    op1(rw(5'd3, 5'd1, 5'd4, 5'd0, FN_SUM_TRAP), 1'b1);
    rd(5'd4, '0);
    op1(rw(5'd3, 5'd1, 5'd5, 5'd0, FN_SUM_NOTRAP), 1'b0);
    rd(5'd5, 64'h7fffffff);
    op1(iw(OP_SUM_TRAP_IMM, 5'd5, 5'd6, 16'h0001), 1'b1);
    op1(iw(OP_SUM_NOTRAP_IMM, 5'd5, 5'd6, 16'h0001), 1'b0);
    rd(5'd6, 64'hffffffff80000000);
    op1(rw(5'd1, 5'd1, 5'd7, 5'd0, FN_SUM_TRAP), 1'b0);
    rd(5'd7, 64'hfffffffffffffffe);
    // a nonzero shift field is not a sum, so nothing is written
    op1(rw(5'd1, 5'd1, 5'd7, 5'd1, FN_SUM_TRAP), 1'b0);
    rd(5'd7, 64'hfffffffffffffffe);
    op1(iw(OP_SUM_NOTRAP_IMM, 5'd1, 5'd0, 16'h0005), 1'b0);
    rd(5'd0, '0);
  endtask
  task automatic t_conj();
    op1(rw(5'd1, 5'd5, 5'd8, 5'd0, FN_CONJ), 1'b0);
    rd(5'd8, 64'h7fffffff);
    op1(iw(OP_CONJ_IMM, 5'd1, 5'd9, 16'h8001), 1'b0);
    rd(5'd9, 64'h8001);
  endtask
  task automatic t_branch();
    br(iw(OP_BR_EQ, 5'd1, 5'd1, 16'hfffe), 32'h0, 1'b1, 1'b0);
    br(iw(OP_BR_EQ, 5'd1, 5'd5, 16'h0010), 32'h0, 1'b0, 1'b0);
    br(iw(OP_BR_EQ_LIKELY, 5'd1, 5'd5, 16'h0010), iw(OP_SUM_NOTRAP_IMM, 5'd0, 5'd10, 16'h7), 1'b0, 1'b1);
    rd(5'd10, '0);
  endtask
  task automatic t_slot_exc();
    logic [63:0] bp;
    bp = pc;
    ex(iw(OP_BR_EQ, 5'd1, 5'd1, 16'h0004));
    ex(rw(5'd3, 5'd1, 5'd4, 5'd0, FN_SUM_TRAP));
    fin();
    chk("slot ovf", ovfException, 1'b1);
    chk("epc", exceptionReturnPc, bp);
    rd(5'd4, '0);
  endtask
  task automatic t_cond();
    for (int k = 0; k < 8; k++) begin
      @(posedge clk_sys);
      statusCond <= k[2];
      repeat (4) @(posedge clk_sys);
      ex(32'h0);
      br(iw(OP_SYSCTL, SUB_BRANCH, {3'h0, k[1:0]}, 16'h0020), 32'h0, k[0] == k[2], k[1]);
    end
  endtask
  task automatic t_move();
    for (int k = 0; k < 2; k++) begin
      ex(iw(OP_SYSCTL, k ? SUB_MOVE_TO : SUB_MOVE_FROM, 5'd3, 16'h6000));
      fin();
      chk("move", scMoveValid, 1'b1);
      chk("dir", scMoveTo, k[0]);
      chk("sc idx", scRegIdx, 5'd12);
      chk("gpr idx", scGprIdx, 5'd3);
    end
  endtask
  task automatic printVerdict();
    $display("checks %0d errors %0d", numChecks, nErrors);
    if (nErrors == 0 && numChecks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge clk_sys);
    rstn <= 1'b1;
    t_sum();
    t_conj();
    t_branch();
    t_slot_exc();
    t_cond();
    t_move();
    printVerdict();
  end
  // the whole run needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clk_sys);
    nErrors++;
    printVerdict();
  end
endmodule
`default_nettype wire
